// ---- hdl/port_status_pkg.sv ----
`default_nettype none
package port_status_pkg;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b01,
    LINK_FRAME = 2'b10
  } linkState_t;

  typedef logic [15:0][15:0] fifoMem_t;

  typedef struct packed {
    logic sck1;
    logic sck2;
    logic sckPrev;
    logic fs1;
    logic fs2;
    logic fsPrev;
    logic din1;
    logic din2;
    linkState_t linkState;
    logic [5:0] bitCnt;
    logic txActive;
    logic [15:0] txShift;
    logic [15:0] txLast;
    logic [15:0] rxShift;
    fifoMem_t txMem;
    logic [3:0] txWr;
    logic [3:0] txRd;
    logic [4:0] txCnt;
    fifoMem_t rxMem;
    logic [3:0] rxWr;
    logic [3:0] rxRd;
    logic [4:0] rxCnt;
    logic [31:0] txCtrlData;
    logic [31:0] rxCtrlData;
    logic [15:0] status;
    logic [15:0] irqEn;
    logic txEn;
    logic rxEn;
    logic [2:0] txWm;
    logic [2:0] rxWm;
    logic [1:0] txSlot;
    logic [1:0] rxSlot;
    logic [1:0] ctrlSlot;
    logic ctrlEn;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic txDmaReq;
    logic rxDmaReq;
    logic sdo;
  } state_t;

endpackage
`default_nettype wire

// ---- hdl/port_status_regs.svh ----
`ifndef PORT_STATUS_REGS_SVH
`define PORT_STATUS_REGS_SVH

// Register byte offsets on the APB side
`define OFS_STATUS 8'h00
`define OFS_IRQ_EN 8'h04
`define OFS_CONTROL 8'h08
`define OFS_FIFO_CTRL 8'h0c
`define OFS_SLOT 8'h10
`define OFS_TX_DATA 8'h14
`define OFS_RX_DATA 8'h18
`define OFS_TX_CTRL 8'h1c
`define OFS_RX_CTRL 8'h20

// Status and irq enable bit positions
`define BIT_TX_ROUTE 15
`define BIT_TX_CTRL_READY 14
`define BIT_TX_FIFO_EMPTY 13
`define BIT_TX_REQ 12
`define BIT_RX_ROUTE 11
`define BIT_RX_CTRL_READY 10
`define BIT_RX_FIFO_FULL 9
`define BIT_RX_REQ 8
`define BIT_SLOT_ERR 5
`define BIT_FSYNC_ERR 4
`define BIT_TX_OVF 3
`define BIT_TX_UDF 2
`define BIT_RX_UDF 1
`define BIT_RX_OVF 0
`define ERR_MASK 16'h003f
`define STATUS_MASK 16'h773f
`define IRQ_EN_MASK 16'hff3f

// Control register bits
`define BIT_TX_EN 9
`define BIT_RX_EN 8
`define BIT_TX_RST 1
`define BIT_RX_RST 0

// FIFO control fields
`define POS_TX_WM 13
`define POS_TX_SPACE 8
`define POS_RX_WM 5
`define POS_RX_COUNT 0

// Slot assignment fields
`define POS_TX_SLOT 0
`define POS_RX_SLOT 4
`define POS_CTRL_SLOT 8
`define BIT_CTRL_EN 12

// FIFO depth and frame geometry
`define FIFO_DEPTH 5'd16
`define SLOT_LAST_BIT 4'hf
`define FRAME_LAST_BIT 6'h3f

// Reset values
`define RST_STATUS 16'h0000
`define RST_IRQ_EN 16'h0000
`define RST_WM 3'h0

`endif

// ---- hdl/serial_port_status_flags.sv ----
// Functional notes
// - Sixteen-bit status; each flag raises the interrupt when its enable bit is set.
// - Transmit control ready reads one when writable; writing that register clears it.
// - Transmit empty reads one while FIFO empty; a transmit data write clears it.
// - Transmit request is one while free space reaches the transmit watermark.
// - Each DMA access clears transmit request; it returns when the condition holds.
// - Receive control ready set on capture, cleared by read; new data overwrites.
// - Receive full reads one while FIFO full; reading receive data clears it.
// - Receive request is one while stored words reach the receive watermark.
// - Each DMA access clears receive request; it returns when the condition holds.
// - Overlapping slot assignments set slot error; no shifting or capture meanwhile.
// - A slot error leaves transmit and receive enable bits untouched.
// - Early frame sync sets frame sync error; completed slots still transfer.
// - Error bits five to zero are sticky, cleared by writing one.
// - Writing transmit data into a full FIFO sets overflow and drops the write.
// - Loading the shifter from an empty FIFO sets underflow; previous word resent.
// - Reading receive data from an empty FIFO sets receive underflow.
// - Received word arriving at a full FIFO sets overflow and is dropped.
// - Reserved status bits fifteen, eleven, seven and six read zero.
// - Transmit-side flags act only while transmit enable is one.
// - Receive-side flags act only while receive enable is one.
// - Transmit reset clears control ready, empty, request and the write pointer.
// - Receive reset clears control ready, full, request and the read pointer.
// - Route select sends each transfer request to the interrupt or to DMA.
`default_nettype none
`include "port_status_regs.svh"

module serial_port_status_flags
  import port_status_pkg::*;
(
  input wire logic clk_sys, // System clock, 40 MHz
  input wire logic rst_n, // Synchronous reset
  input wire logic [7:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic serialClockIn, // Link bit clock from codec
  input wire logic frameSyncIn, // Link frame sync from codec
  input wire logic serialDataIn, // Link receive data
  output logic serialDataOut, // Link transmit data
  input wire logic txDmaAck, // One DMA access to transmit data done
  input wire logic rxDmaAck, // One DMA access to receive data done
  output logic txDmaReq, // Transmit request routed to DMA
  output logic rxDmaReq, // Receive request routed to DMA
  output logic irq // Interrupt to CPU
);

  state_t q;
  state_t d;
  logic sckRise;
  logic sckFall;
  logic fsRise;
  logic acc;
  logic wrAcc;
  logic rdAcc;
  logic mapped;
  logic [31:0] rdata;
  logic [5:0] setErr;
  logic txPush;
  logic txPop;
  logic rxPush;
  logic rxPop;
  logic transmit_reset;
  logic receive_reset;
  logic txCtrlWr;
  logic rxCtrlRd;
  logic halted;
  logic [1:0] slot;
  logic [15:0] word;
  logic [15:0] rxWord;
  logic [4:0] txSpace;
  logic [15:0] irqSrc;

  function automatic logic txWmHit(input logic [2:0] wm, input logic [4:0] space);
    case (wm)
      3'h4: txWmHit = space >= 5'd12;
      3'h5: txWmHit = space >= 5'd8;
      3'h6: txWmHit = space >= 5'd4;
      3'h7: txWmHit = space >= 5'd1;
      default: txWmHit = space >= 5'd16;
    endcase
  endfunction

  function automatic logic rxWmHit(input logic [2:0] wm, input logic [4:0] cnt);
    case (wm)
      3'h4: rxWmHit = cnt >= 5'd4;
      3'h5: rxWmHit = cnt >= 5'd8;
      3'h6: rxWmHit = cnt >= 5'd12;
      3'h7: rxWmHit = cnt >= 5'd16;
      default: rxWmHit = cnt >= 5'd1;
    endcase
  endfunction

  always_comb
  begin
    d = q;
    setErr = 6'h00;
    word = 16'h0000;
    rxWord = {q.rxShift[14:0], q.din2};
    slot = q.bitCnt[5:4];
    txPop = 1'b0;
    rxPush = 1'b0;
    // Two-stage synchronisers; only the second stage feeds logic
    d.sck1 = serialClockIn;
    d.sck2 = q.sck1;
    d.sckPrev = q.sck2;
    d.fs1 = frameSyncIn;
    d.fs2 = q.fs1;
    d.fsPrev = q.fs2;
    d.din1 = serialDataIn;
    d.din2 = q.din1;
    sckRise = q.sck2 & ~q.sckPrev;
    sckFall = ~q.sck2 & q.sckPrev;
    fsRise = q.fs2 & ~q.fsPrev;

    // Read mux; reserved bits come back as zero
    mapped = 1'b1;
    case (paddr)
      `OFS_STATUS: rdata = {16'h0000, q.status & `STATUS_MASK};
      `OFS_IRQ_EN: rdata = {16'h0000, q.irqEn};
      `OFS_CONTROL: rdata = {22'h000000, q.txEn, q.rxEn, 8'h00};
      `OFS_FIFO_CTRL: rdata = {16'h0000, q.txWm, `FIFO_DEPTH - q.txCnt, q.rxWm, q.rxCnt};
      `OFS_SLOT: rdata = {19'h00000, q.ctrlEn, 2'h0, q.ctrlSlot, 2'h0, q.rxSlot, 2'h0, q.txSlot};
      `OFS_TX_DATA: rdata = 32'h00000000;
      `OFS_RX_DATA: rdata = {16'h0000, q.rxMem[q.rxRd]};
      `OFS_TX_CTRL: rdata = q.txCtrlData;
      `OFS_RX_CTRL: rdata = q.rxCtrlData;
      default:
      begin
        rdata = 32'h00000000;
        mapped = 1'b0;
      end
    endcase

    // Answer in the first access cycle; effects take place at that edge
    d.pready = psel & ~penable;
    d.pslverr = psel & ~penable & ~mapped;
    if (psel && !penable)
    begin
      d.prdata = rdata;
    end
    acc = psel & penable & q.pready & ~q.pslverr;
    wrAcc = acc & pwrite;
    rdAcc = acc & ~pwrite;
    txPush = wrAcc && paddr == `OFS_TX_DATA;
    rxPop = rdAcc && paddr == `OFS_RX_DATA;
    txCtrlWr = wrAcc && paddr == `OFS_TX_CTRL;
    rxCtrlRd = rdAcc && paddr == `OFS_RX_CTRL;
    transmit_reset = wrAcc && paddr == `OFS_CONTROL && pwdata[`BIT_TX_RST];
    receive_reset = wrAcc && paddr == `OFS_CONTROL && pwdata[`BIT_RX_RST];

    if (wrAcc)
    begin
      case (paddr)
        `OFS_IRQ_EN: d.irqEn = pwdata[15:0] & `IRQ_EN_MASK;
        `OFS_CONTROL:
        begin
          d.txEn = pwdata[`BIT_TX_EN];
          d.rxEn = pwdata[`BIT_RX_EN];
        end
        `OFS_FIFO_CTRL:
        begin
          d.txWm = pwdata[`POS_TX_WM +: 3];
          d.rxWm = pwdata[`POS_RX_WM +: 3];
        end
        `OFS_SLOT:
        begin
          d.txSlot = pwdata[`POS_TX_SLOT +: 2];
          d.rxSlot = pwdata[`POS_RX_SLOT +: 2];
          d.ctrlSlot = pwdata[`POS_CTRL_SLOT +: 2];
          d.ctrlEn = pwdata[`BIT_CTRL_EN];
        end
        `OFS_TX_CTRL: d.txCtrlData = pwdata;
        `OFS_RX_CTRL: d.rxCtrlData = pwdata;
        default: d.irqEn = q.irqEn;
      endcase
    end

    // Transmit FIFO write side; a full FIFO discards the word
    if (txPush)
    begin
      if (q.txCnt == `FIFO_DEPTH)
      begin
        setErr[`BIT_TX_OVF] = q.txEn;
        txPush = 1'b0;
      end
      else
      begin
        d.txMem[q.txWr] = pwdata[15:0];
        d.txWr = q.txWr + 4'h1;
      end
    end
    if (rxPop)
    begin
      if (q.rxCnt == 5'd0)
      begin
        setErr[`BIT_RX_UDF] = q.rxEn;
        rxPop = 1'b0;
      end
      else
      begin
        d.rxRd = q.rxRd + 4'h1;
      end
    end

    // Overlap check runs continuously; a sticky error stops the shifter
    if (q.ctrlEn && ((q.txEn && q.txSlot == q.ctrlSlot) || (q.rxEn && q.rxSlot == q.ctrlSlot)))
    begin
      setErr[`BIT_SLOT_ERR] = 1'b1;
    end
    halted = q.status[`BIT_SLOT_ERR];
    if (rxCtrlRd)
    begin
      d.status[`BIT_RX_CTRL_READY] = 1'b0;
    end

    case (q.linkState)
      LINK_IDLE:
      begin
        d.sdo = 1'b1;
        if (fsRise)
        begin
          d.linkState = LINK_FRAME;
          d.bitCnt = 6'h00;
        end
      end
      LINK_FRAME:
      begin
        if (fsRise)
        begin
          // Slots already finished stay delivered; the frame restarts
          setErr[`BIT_FSYNC_ERR] = q.txEn | q.rxEn;
          d.bitCnt = 6'h00;
          d.txActive = 1'b0;
          d.sdo = 1'b1;
        end
        else
        begin
          if (sckFall && !halted)
          begin
            if (q.bitCnt[3:0] == 4'h0)
            begin
              d.txActive = 1'b0;
              d.sdo = 1'b1;
              if (q.txEn && slot == q.txSlot)
              begin
                if (q.txCnt == 5'd0)
                begin
                  setErr[`BIT_TX_UDF] = 1'b1;
                  word = q.txLast;
                end
                else
                begin
                  word = q.txMem[q.txRd];
                  txPop = 1'b1;
                  d.txRd = q.txRd + 4'h1;
                end
                d.txLast = word;
                d.txActive = 1'b1;
              end
              else if (q.txEn && q.ctrlEn && slot == q.ctrlSlot)
              begin
                word = q.bitCnt[5] ? q.txCtrlData[15:0] : q.txCtrlData[31:16];
                d.status[`BIT_TX_CTRL_READY] = 1'b1;
                d.txActive = 1'b1;
              end
              if (d.txActive)
              begin
                d.sdo = word[15];
                d.txShift = {word[14:0], 1'b0};
              end
            end
            else if (q.txActive)
            begin
              d.sdo = q.txShift[15];
              d.txShift = {q.txShift[14:0], 1'b0};
            end
          end
          if (sckRise)
          begin
            if (!halted)
            begin
              d.rxShift = rxWord;
              if (q.bitCnt[3:0] == `SLOT_LAST_BIT && q.rxEn)
              begin
                if (slot == q.rxSlot)
                begin
                  if (q.rxCnt == `FIFO_DEPTH)
                  begin
                    setErr[`BIT_RX_OVF] = 1'b1;
                  end
                  else
                  begin
                    rxPush = 1'b1;
                    d.rxMem[q.rxWr] = rxWord;
                    d.rxWr = q.rxWr + 4'h1;
                  end
                end
                else if (q.ctrlEn && slot == q.ctrlSlot)
                begin
                  // Unread control data is simply overwritten
                  d.rxCtrlData = {rxWord, q.rxCtrlData[31:16]};
                  d.status[`BIT_RX_CTRL_READY] = 1'b1;
                end
              end
            end
            d.bitCnt = q.bitCnt + 6'h01;
            if (q.bitCnt == `FRAME_LAST_BIT)
            begin
              d.linkState = LINK_IDLE;
            end
          end
        end
      end
      default: d.linkState = LINK_IDLE;
    endcase
    if (!q.txEn || halted)
    begin
      d.sdo = 1'b1;
    end

    d.txCnt = q.txCnt + {4'h0, txPush} - {4'h0, txPop};
    d.rxCnt = q.rxCnt + {4'h0, rxPush} - {4'h0, rxPop};
    txSpace = `FIFO_DEPTH - d.txCnt;

    if (txCtrlWr)
    begin
      d.status[`BIT_TX_CTRL_READY] = 1'b0;
    end
    d.status[`BIT_TX_FIFO_EMPTY] = q.txEn && d.txCnt == 5'd0 && !txPush;
    d.status[`BIT_TX_REQ] = q.txEn && txWmHit(q.txWm, txSpace) && !txDmaAck;
    d.status[`BIT_RX_FIFO_FULL] = q.rxEn && d.rxCnt == `FIFO_DEPTH && !rxPop;
    d.status[`BIT_RX_REQ] = q.rxEn && rxWmHit(q.rxWm, d.rxCnt) && !rxDmaAck;

    // Write-one clears; a same-cycle hardware event still lands
    if (wrAcc && paddr == `OFS_STATUS)
    begin
      d.status[5:0] = q.status[5:0] & ~pwdata[5:0];
    end
    d.status[5:0] = d.status[5:0] | setErr;

    if (transmit_reset)
    begin
      d.status[`BIT_TX_CTRL_READY] = 1'b0;
      d.status[`BIT_TX_FIFO_EMPTY] = 1'b0;
      d.status[`BIT_TX_REQ] = 1'b0;
      d.txWr = 4'h0;
      d.txRd = 4'h0;
      d.txCnt = 5'd0;
      d.txEn = 1'b0;
      d.txActive = 1'b0;
      d.sdo = 1'b1;
    end
    if (receive_reset)
    begin
      d.status[`BIT_RX_CTRL_READY] = 1'b0;
      d.status[`BIT_RX_FIFO_FULL] = 1'b0;
      d.status[`BIT_RX_REQ] = 1'b0;
      d.rxRd = 4'h0;
      d.rxWr = 4'h0;
      d.rxCnt = 5'd0;
      d.rxEn = 1'b0;
    end
    d.status = d.status & `STATUS_MASK;

    // Requests routed to DMA are kept off the CPU interrupt
    irqSrc = d.status & d.irqEn;
    irqSrc[`BIT_TX_REQ] = irqSrc[`BIT_TX_REQ] & ~d.irqEn[`BIT_TX_ROUTE];
    irqSrc[`BIT_RX_REQ] = irqSrc[`BIT_RX_REQ] & ~d.irqEn[`BIT_RX_ROUTE];
    d.irq = |(irqSrc & `STATUS_MASK);
    d.txDmaReq = d.irqEn[`BIT_TX_ROUTE] & d.irqEn[`BIT_TX_REQ] & d.status[`BIT_TX_REQ];
    d.rxDmaReq = d.irqEn[`BIT_RX_ROUTE] & d.irqEn[`BIT_RX_REQ] & d.status[`BIT_RX_REQ];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.linkState <= LINK_IDLE;
      q.status <= `RST_STATUS;
      q.irqEn <= `RST_IRQ_EN;
      q.txWm <= `RST_WM;
      q.rxWm <= `RST_WM;
      q.sdo <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign serialDataOut = q.sdo;
  assign txDmaReq = q.txDmaReq;
  assign rxDmaReq = q.rxDmaReq;
  assign irq = q.irq;

endmodule
`default_nettype wire

// ---- test/codec_link_model.sv ----
`default_nettype none
module codec_link_model (
  output logic sck, // Bit clock, high while idle
  output logic fs, // Frame sync
  output logic sd, // Data to the port
  input wire logic sdo, // Data from the port
  output logic [15:0] txWord // First slot word seen on the line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sck = 1'b1;
    fs = 1'b0;
    sd = 1'b0;
    txWord = 16'h0000;
  end
  // Sampling late in the bit leaves room for the port's resync delay
  task automatic frame(input int nb, input logic [15:0] w);
    fs = 1'b1;
    #100;
    // One bit every 200 ns: low half, then high half
    for (int i = 0; i < nb; i++)
    begin
      sck = 1'b0;
      fs = (i == 0);
      sd = (i < 16) ? w[15 - i] : ~sd;
      #100 sck = 1'b1;
      #95 if (i < 16) txWord = {txWord[14:0], sdo};
      #5;
    end
    // Clock stands still between frames; the data line keeps moving
    repeat (8) #50 sd = ~sd;
  endtask
endmodule
`default_nettype wire

// ---- test/serial_port_status_flags_sva.sv ----
`default_nettype none
module serial_port_status_flags_sva (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic [7:0] paddr, // Address
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic serialDataOut, // Link out
  input wire logic txDmaAck, // Tx ack
  input wire logic rxDmaAck, // Rx ack
  input wire logic txDmaReq, // Tx request
  input wire logic rxDmaReq, // Rx request
  input wire logic irq // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  sequence setupPh;
    psel && !penable;
  endsequence
  sequence accessPh;
    psel && penable && pready;
  endsequence
  AST_APB_ONE_WAIT: assert property (setupPh |=> accessPh)
    else $error("ready missing in access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  AST_ERR_READY: assert property (pslverr |-> accessPh)
    else $error("error outside access cycle");
  AST_ERR_MAP: assert property (pready && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 8'h20))
    else $error("error response does not match address map");
  AST_RSV_ZERO: assert property (accessPh and !pwrite && paddr == 8'h00 |->
    prdata[31:16] == 16'h0000 && !prdata[15] && !prdata[11] && prdata[7:6] == 2'b00)
    else $error("reserved status bit read as one");
  AST_TX_DMA_ACK: assert property (txDmaAck |=> !txDmaReq)
    else $error("tx request survived an ack");
  AST_RX_DMA_ACK: assert property (rxDmaAck |=> !rxDmaReq)
    else $error("rx request survived an ack");
  AST_RST_QUIET: assert property ($rose(rst_n) |-> !irq && serialDataOut && !txDmaReq
    && !rxDmaReq && !pready)
    else $error("outputs active after reset");
endmodule
`default_nettype wire

// ---- test/serial_port_status_flags_test.sv ----
`default_nettype none
`include "port_status_regs.svh"
module serial_port_status_flags_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_n, psel, penable, pwrite, txDmaAck, rxDmaAck, err;
  logic pready, pslverr, sdo, txDmaReq, rxDmaReq, irq, sck, fs, sd;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] txWord, w, t0, t1;
  logic [15:0] q [$];
  logic [2:0] wm;
  logic [2:0] wmTab [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
  int n_fail = 0;
  int total_checks = 0;
  int seed = 32'h2c43;
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  serial_port_status_flags serial_port_status_flags_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .serialClockIn(sck),
    .frameSyncIn(fs), .serialDataIn(sd), .serialDataOut(sdo), .txDmaAck(txDmaAck),
    .rxDmaAck(rxDmaAck), .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq), .irq(irq));
  codec_link_model codec_link_model_inst (.sck(sck), .fs(fs), .sd(sd), .sdo(sdo),
    .txWord(txWord));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20) n_fail++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ack(input logic tx);
    @(posedge clk_sys);
    if (tx) txDmaAck <= 1'b1;
    else rxDmaAck <= 1'b1;
    @(posedge clk_sys);
    txDmaAck <= 1'b0;
    rxDmaAck <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  function automatic logic txReqExp(input int fr, input logic [2:0] m);
    case (m)
      3'h4: return fr >= 12;
      3'h5: return fr >= 8;
      3'h6: return fr >= 4;
      3'h7: return fr >= 1;
      default: return fr >= 16;
    endcase
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #1000000;
    n_fail++;
    stop_test();
  end
  initial
  begin
    rst_n = 1'b0;
    {psel, penable, pwrite, txDmaAck, rxDmaAck, paddr, pwdata} = '0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("status reset", rd, {16'h0, `RST_STATUS});
    w = 16'($random(seed));
    apb(1'b1, `OFS_IRQ_EN, {16'h0, w});
    apb(1'b0, `OFS_IRQ_EN, 32'h0);
    chk("irq enable", rd, {16'h0, w & `IRQ_EN_MASK});
    apb(1'b1, `OFS_IRQ_EN, 32'h0);
    apb(1'b1, `OFS_CONTROL, 32'h300);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("status enabled", rd, 32'h3000);
    apb(1'b1, `OFS_IRQ_EN, 32'h9000);
    repeat (2) @(posedge clk_sys);
    chk("tx dma request", txDmaReq, 1'b1);
    chk("irq while routed", irq, 1'b0);
    ack(1'b1);
    chk("tx request back", txDmaReq, 1'b1);
    apb(1'b1, `OFS_IRQ_EN, 32'h0);
    $display("test registers done");
    w = 16'($random(seed));
    codec_link_model_inst.frame(64, w);
    apb(1'b1, `OFS_STATUS, 32'h0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("status after frame", rd, 32'h3104);
    apb(1'b1, `OFS_IRQ_EN, 32'h0900);
    repeat (2) @(posedge clk_sys);
    chk("rx dma request", rxDmaReq, 1'b1);
    ack(1'b0);
    chk("rx request back", rxDmaReq, 1'b1);
    apb(1'b1, `OFS_IRQ_EN, 32'h0);
    apb(1'b0, `OFS_RX_DATA, 32'h0);
    chk("rx word", rd[15:0], w);
    apb(1'b1, `OFS_STATUS, 32'h4);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("clear by one", rd, 32'h3000);
    apb(1'b0, `OFS_RX_DATA, 32'h0);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("rx underflow", rd, 32'h3002);
    apb(1'b1, `OFS_STATUS, 32'h3f);
    $display("test frame done");
    wm = wmTab[$unsigned($random(seed)) % 5];
    apb(1'b1, `OFS_FIFO_CTRL, {16'h0, wm, 13'h0});
    for (int i = 1; i <= 17; i++)
    begin
      w = 16'($random(seed));
      if (i == 1) t0 = w;
      if (i == 16) t1 = w;
      apb(1'b1, `OFS_TX_DATA, {16'h0, w});
      apb(1'b0, `OFS_STATUS, 32'h0);
      chk("tx empty", rd[13], 1'b0);
      chk("tx request", rd[12], txReqExp(16 - ((i > 16) ? 16 : i), wm));
      chk("tx overflow", rd[3], i > 16);
    end
    apb(1'b0, `OFS_FIFO_CTRL, 32'h0);
    chk("tx free space", rd[12:8], 5'd0);
    apb(1'b1, `OFS_IRQ_EN, 32'h8);
    repeat (2) @(posedge clk_sys);
    chk("irq raised", irq, 1'b1);
    apb(1'b1, `OFS_STATUS, 32'h8);
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", irq, 1'b0);
    apb(1'b1, `OFS_IRQ_EN, 32'h0);
    $display("test fill done");
    for (int i = 0; i < 17; i++)
    begin
      w = 16'($random(seed));
      if (i < 16) q.push_back(w);
      codec_link_model_inst.frame(64, w);
      if (i == 0) chk("tx line word", txWord, t0);
      if (i == 16) chk("tx resend", txWord, t1);
    end
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("rx full", rd[9], 1'b1);
    chk("rx overflow", rd[0], 1'b1);
    chk("tx underflow", rd[2], 1'b1);
    apb(1'b0, `OFS_FIFO_CTRL, 32'h0);
    chk("rx count", rd[4:0], `FIFO_DEPTH);
    for (int i = 0; i < 16; i++)
    begin
      apb(1'b0, `OFS_RX_DATA, 32'h0);
      chk("rx data", rd[15:0], q[i]);
      if (i == 0) apb(1'b0, `OFS_STATUS, 32'h0);
      if (i == 0) chk("full cleared", rd[9], 1'b0);
    end
    $display("test overflow done");
    apb(1'b1, `OFS_SLOT, 32'h1200);
    w = 16'($random(seed));
    codec_link_model_inst.frame(64, w);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("tx ctrl ready", rd[14], 1'b1);
    chk("rx ctrl ready", rd[10], 1'b1);
    apb(1'b1, `OFS_TX_CTRL, {16'h0, w});
    apb(1'b0, `OFS_RX_CTRL, 32'h0);
    chk("rx ctrl word", rd[31:16], w[0] ? 16'h5555 : 16'haaaa);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("tx ctrl taken", rd[14], 1'b0);
    chk("rx ctrl taken", rd[10], 1'b0);
    apb(1'b0, `OFS_RX_DATA, 32'h0);
    chk("rx slot word", rd[15:0], w);
    $display("test control data done");
    apb(1'b1, `OFS_SLOT, 32'h1000);
    codec_link_model_inst.frame(64, 16'($random(seed)));
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("slot error", rd[5], 1'b1);
    apb(1'b0, `OFS_FIFO_CTRL, 32'h0);
    chk("no capture", rd[4:0], 5'd0);
    apb(1'b0, `OFS_CONTROL, 32'h0);
    chk("enables kept", rd[9:8], 2'b11);
    apb(1'b1, `OFS_SLOT, 32'h0);
    apb(1'b1, `OFS_STATUS, 32'h3f);
    codec_link_model_inst.frame(20, 16'($random(seed)));
    codec_link_model_inst.frame(64, 16'($random(seed)));
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("frame sync error", rd[4], 1'b1);
    apb(1'b0, `OFS_FIFO_CTRL, 32'h0);
    chk("cut frame slots kept", rd[4:0], 5'd2);
    $display("test link errors done");
    apb(1'b1, `OFS_TX_DATA, {16'h0, w});
    apb(1'b1, `OFS_CONTROL, 32'h302);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("tx reset", rd[14:12], 3'h0);
    apb(1'b0, `OFS_FIFO_CTRL, 32'h0);
    chk("tx pointer reset", rd[12:8], `FIFO_DEPTH);
    chk("rx kept", rd[4:0], 5'd2);
    apb(1'b1, `OFS_CONTROL, 32'h1);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk("rx reset", rd[10:8], 3'h0);
    apb(1'b0, `OFS_FIFO_CTRL, 32'h0);
    chk("rx pointer reset", rd[4:0], 5'd0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", err, 1'b1);
    $display("test resets done");
    stop_test();
  end
endmodule
bind serial_port_status_flags serial_port_status_flags_sva serial_port_status_flags_sva_inst (
  .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serialDataOut(serialDataOut), .txDmaAck(txDmaAck), .rxDmaAck(rxDmaAck),
  .txDmaReq(txDmaReq), .rxDmaReq(rxDmaReq), .irq(irq));
`default_nettype wire
